// ### dps_pkg.sv
`default_nettype none
package dps_pkg;

  // ********************************************************
  // timing
  // ********************************************************
  localparam int unsigned CLK_FREQ_KHZ = 25000;
  localparam int unsigned FUNC_DELAY_MS = 1;
  localparam int unsigned FUNC_DELAY_CYC = FUNC_DELAY_MS * CLK_FREQ_KHZ;
  localparam int unsigned SW_FREQ_HI_KHZ = 2100;
  localparam int unsigned SW_FREQ_LO_KHZ = 420;
  // longest period rounds down to whole cycles
  localparam int unsigned SW_HI_CYC = CLK_FREQ_KHZ / SW_FREQ_HI_KHZ;
  localparam int unsigned SW_LO_CYC = CLK_FREQ_KHZ / SW_FREQ_LO_KHZ;

  // ********************************************************
  // register map (byte addresses)
  // ********************************************************
  localparam logic [4:0] REG_CTRL_OFS = 5'h00;
  localparam logic [4:0] CONFIG_OFS = 5'h04;
  localparam logic [4:0] AVDD_SET_OFS = 5'h08;
  localparam logic [4:0] VGON_SET_OFS = 5'h0C;
  localparam logic [4:0] VGOFF_SET_OFS = 5'h10;
  localparam logic [4:0] SECOND_FAULT_REG_OFS = 5'h14;
  localparam logic [4:0] STATUS_OFS = 5'h18;

  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_COMMIT_BIT = 1;
  localparam int unsigned CFG_FSW_BIT = 0;
  localparam int unsigned CFG_SS_BIT = 1;
  localparam int unsigned CFG_DBL_BIT = 2;
  localparam int unsigned CFG_SEQ_LSB = 4;
  localparam int unsigned FLT2_OOR_BIT = 0;
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_SERIAL_BIT = 2;
  localparam int unsigned STAT_RO_BIT = 3;
  localparam int unsigned STAT_PIN_BIT = 4;
  localparam int unsigned STAT_ADDR_LSB = 8;

  // ********************************************************
  // reset and default values
  // ********************************************************
  localparam logic [5:0] AVDD_DEF = 6'h14;
  localparam logic [5:0] VGON_DEF = 6'h20;
  localparam logic [5:0] VGOFF_DEF = 6'h18;
  localparam logic [2:0] SEQ_DEF = 3'h2;
  localparam logic [6:0] RO_SERIAL_ADDR = 7'h29;
  // arbitrary value, address of the writable mode
  localparam logic [6:0] RW_SERIAL_ADDR = 7'h2A;

  // ********************************************************
  // types
  // ********************************************************
  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_CORE = 2'h1,
    ST_READY = 2'h3,
    ST_ON = 2'h2
  } dps_state_t;

  typedef enum logic [1:0] {
    STRAP_LOW = 2'h0,
    STRAP_FLOAT = 2'h1,
    STRAP_CORE = 2'h2
  } dps_strap_t;

endpackage
`default_nettype wire

// ### dps_sw_clk.sv
`timescale 1ns/10ps
`default_nettype none
module dps_sw_clk (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic i_freq_low,
  input wire logic i_ss_en,
  output logic o_sw_tick
);
  import dps_pkg::*;

  logic [6:0] cnt_q;
  logic [1:0] dith_q;
  logic dith_dn_q;
  logic [6:0] period;

  // dither stretches the period by 0..3 cycles in a triangle
  always_comb begin
    period = i_freq_low ? 7'(SW_LO_CYC) : 7'(SW_HI_CYC);
    if (i_ss_en) begin
      period = period + {5'h00, dith_q};
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_q <= 7'h00;
      o_sw_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_q <= 7'h00;
      o_sw_tick <= 1'b0;
    end else if (cnt_q >= period - 7'h01) begin
      cnt_q <= 7'h00;
      o_sw_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      o_sw_tick <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dith_q <= 2'h0;
      dith_dn_q <= 1'b0;
    end else if (o_sw_tick) begin
      if (dith_dn_q) begin
        dith_q <= dith_q - 2'h1;
        dith_dn_q <= (dith_q != 2'h1);
      end else begin
        dith_q <= dith_q + 2'h1;
        dith_dn_q <= (dith_q == 2'h2);
      end
    end
  end

  // tick spacing helper
  logic [6:0] gap_q;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gap_q <= 7'h00;
    end else if (o_sw_tick) begin
      gap_q <= 7'h01;
    end else if (gap_q != 7'h7F) begin
      gap_q <= gap_q + 7'h01;
    end
  end

  // a period is only judged when run, rate and dither held still across it
  logic [2:0] mode_q;
  logic [6:0] calm_q;
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mode_q <= 3'h0;
      calm_q <= 7'h00;
    end else begin
      mode_q <= {i_run, i_freq_low, i_ss_en};
      if (mode_q != {i_run, i_freq_low, i_ss_en}) begin
        calm_q <= 7'h00;
      end else if (calm_q != 7'h7F) begin
        calm_q <= calm_q + 7'h01;
      end
    end
  end

  chk_tick_period_hi: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (o_sw_tick && $past(o_sw_tick, 2) == 1'b0 && !i_freq_low && !i_ss_en
      && gap_q != 7'h7F && gap_q != 7'h00
      && {1'b0, calm_q} > {1'b0, gap_q} + 8'h02)
      |-> gap_q == 7'(SW_HI_CYC))
    else $error("switch tick spacing wrong at high frequency");

  chk_tick_gap_lo: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (o_sw_tick && i_freq_low && i_run) |=> (!o_sw_tick)[*8])
    else $error("switch tick too early at low frequency");

endmodule // dps_sw_clk
`default_nettype wire

// ### dps_top.sv
`timescale 1ns/10ps
`default_nettype none
module dps_top #(
  parameter int unsigned P_FUNC_DELAY_CYC = dps_pkg::FUNC_DELAY_CYC
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_enable,
  input wire logic i_vin_above_uvlo,
  input wire logic i_core_below_uvlo,
  input wire logic i_core_supply_out_of_range,
  input wire dps_pkg::dps_strap_t i_addr_strap,
  input wire logic i_variant_read_only,
  input wire logic i_nvm_programmed,
  input wire logic [5:0] i_nvm_avdd,
  input wire logic [5:0] i_nvm_vgon,
  input wire logic [5:0] i_nvm_vgoff,
  input wire logic [2:0] i_nvm_seq,
  input wire logic i_fault_out_n_in,
  output logic o_fault_out_n_o,
  output logic o_fault_out_n_oe,
  output logic o_core_reg_en,
  output logic o_functional,
  output logic o_outputs_on,
  output logic o_nvm_commit,
  output logic [5:0] o_avdd_level,
  output logic [5:0] o_negative_source_rail_level,
  output logic [5:0] o_vgon_level,
  output logic [5:0] o_vgoff_level,
  output logic [2:0] o_seq_select,
  output logic o_pump_doubler_select,
  output logic o_switch_freq_select,
  output logic o_spread_en,
  output logic o_sw_tick
);
  import dps_pkg::*;

  // ********************************************************
  // bus slave
  // ********************************************************
  logic ack_q;
  logic req;
  logic rd_acc;
  logic wr_acc;
  logic wr_ok;
  logic ro_mode_q;

  // one wait state: the answer stands at the second edge
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign rd_acc = i_avs_read & ack_q;
  assign wr_acc = i_avs_write & ack_q & i_avs_byteenable[0];
  assign wr_ok = wr_acc & ~ro_mode_q;

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  function automatic logic wr_hit(input logic [4:0] ofs);
    return wr_ok && (i_avs_address == ofs);
  endfunction

  // ********************************************************
  // power-up state machine
  // ********************************************************
  dps_state_t st_q;
  dps_state_t st_d;
  logic [15:0] dly_q;
  logic dly_done;
  logic power_ok;
  logic auto_start_q;
  logic start_req;

  assign power_ok = i_enable & i_vin_above_uvlo & ~i_core_below_uvlo;
  assign dly_done = (dly_q == 16'(P_FUNC_DELAY_CYC - 1));
  // start only counts while waiting in the ready state
  assign start_req = wr_hit(REG_CTRL_OFS)
    && i_avs_writedata[CTRL_START_BIT];

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        st_d = ST_CORE;
      end
      ST_CORE: begin
        if (dly_done) begin
          st_d = ST_READY;
        end
      end
      ST_READY: begin
        if (auto_start_q || start_req) begin
          st_d = ST_ON;
        end
      end
      ST_ON: begin
        st_d = ST_ON;
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
    if (!power_ok) begin
      st_d = ST_OFF;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_q <= ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dly_q <= 16'h0000;
    end else if (st_q != ST_CORE) begin
      dly_q <= 16'h0000;
    end else if (!dly_done) begin
      dly_q <= dly_q + 16'h0001;
    end
  end

  // strap and variant are caught when the core supply comes up
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      auto_start_q <= 1'b0;
      ro_mode_q <= 1'b0;
    end else if (st_q == ST_OFF && power_ok) begin
      auto_start_q <= i_variant_read_only
        || (i_addr_strap == STRAP_FLOAT);
      ro_mode_q <= i_variant_read_only
        && (i_addr_strap == STRAP_CORE);
    end
  end

  // ********************************************************
  // settings
  // ********************************************************
  logic load_now;
  logic [5:0] avdd_q;
  logic [5:0] vgon_q;
  logic [5:0] vgoff_q;
  logic [2:0] seq_q;
  logic fsw_q;
  logic ss_q;
  logic dbl_q;

  assign load_now = (st_q == ST_CORE) && (st_d == ST_READY);

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      avdd_q <= AVDD_DEF;
      vgon_q <= VGON_DEF;
      vgoff_q <= VGOFF_DEF;
      seq_q <= SEQ_DEF;
    end else if (load_now) begin
      avdd_q <= i_nvm_programmed ? i_nvm_avdd : AVDD_DEF;
      vgon_q <= i_nvm_programmed ? i_nvm_vgon : VGON_DEF;
      vgoff_q <= i_nvm_programmed ? i_nvm_vgoff : VGOFF_DEF;
      seq_q <= i_nvm_programmed ? i_nvm_seq : SEQ_DEF;
    end else begin
      if (wr_hit(AVDD_SET_OFS)) begin
        avdd_q <= i_avs_writedata[5:0];
      end
      if (wr_hit(VGON_SET_OFS)) begin
        vgon_q <= i_avs_writedata[5:0];
      end
      if (wr_hit(VGOFF_SET_OFS)) begin
        vgoff_q <= i_avs_writedata[5:0];
      end
      if (wr_hit(CONFIG_OFS)) begin
        seq_q <= i_avs_writedata[CFG_SEQ_LSB +: 3];
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      fsw_q <= 1'b0;
      ss_q <= 1'b0;
      dbl_q <= 1'b0;
    end else if (wr_hit(CONFIG_OFS)) begin
      fsw_q <= i_avs_writedata[CFG_FSW_BIT];
      ss_q <= i_avs_writedata[CFG_SS_BIT];
      dbl_q <= i_avs_writedata[CFG_DBL_BIT];
    end
  end

  // commit pulse lets the memory controller burn the live settings
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_nvm_commit <= 1'b0;
    end else begin
      o_nvm_commit <= wr_hit(REG_CTRL_OFS)
        && i_avs_writedata[CTRL_COMMIT_BIT];
    end
  end

  // ********************************************************
  // fault flag and pin
  // ********************************************************
  logic oor_q;
  logic flt_clr;

  assign flt_clr = rd_acc && (i_avs_address == SECOND_FAULT_REG_OFS);

  // a new event wins over the clear-on-read
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      oor_q <= 1'b0;
    end else if (i_core_supply_out_of_range) begin
      oor_q <= 1'b1;
    end else if (flt_clr) begin
      oor_q <= 1'b0;
    end
  end

  // stand-alone mode leaves the pin released
  assign o_fault_out_n_o = 1'b0;
  assign o_fault_out_n_oe = oor_q && !auto_start_q
    && (st_q != ST_OFF);

  // ********************************************************
  // read data
  // ********************************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (i_avs_address)
      REG_CTRL_OFS: rd_mux[CTRL_START_BIT] = (st_q == ST_ON);
      CONFIG_OFS: begin
        rd_mux[CFG_FSW_BIT] = fsw_q;
        rd_mux[CFG_SS_BIT] = ss_q;
        rd_mux[CFG_DBL_BIT] = dbl_q;
        rd_mux[CFG_SEQ_LSB +: 3] = seq_q;
      end
      AVDD_SET_OFS: rd_mux[5:0] = avdd_q;
      VGON_SET_OFS: rd_mux[5:0] = vgon_q;
      VGOFF_SET_OFS: rd_mux[5:0] = vgoff_q;
      SECOND_FAULT_REG_OFS: rd_mux[FLT2_OOR_BIT] = oor_q;
      STATUS_OFS: begin
        rd_mux[STAT_STATE_LSB +: 2] = st_q;
        rd_mux[STAT_SERIAL_BIT] = !auto_start_q;
        rd_mux[STAT_RO_BIT] = ro_mode_q;
        rd_mux[STAT_PIN_BIT] = i_fault_out_n_in;
        rd_mux[STAT_ADDR_LSB +: 7] = ro_mode_q ? RO_SERIAL_ADDR
          : RW_SERIAL_ADDR;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !ack_q) begin
      o_avs_readdata <= rd_mux;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign o_core_reg_en = (st_q != ST_OFF);
  assign o_functional = (st_q == ST_READY) || (st_q == ST_ON);
  assign o_outputs_on = (st_q == ST_ON);
  assign o_avdd_level = avdd_q;
  assign o_negative_source_rail_level = avdd_q;
  assign o_vgon_level = vgon_q;
  assign o_vgoff_level = vgoff_q;
  assign o_seq_select = seq_q;
  assign o_pump_doubler_select = dbl_q;
  assign o_switch_freq_select = fsw_q;
  assign o_spread_en = ss_q;

  dps_sw_clk u_sw_clk (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_run(o_outputs_on),
    .i_freq_low(fsw_q),
    .i_ss_en(ss_q),
    .o_sw_tick(o_sw_tick)
  );

  // ********************************************************
  // checks
  // ********************************************************
  sequence s_bus_wait;
    req && !ack_q ##1 !o_avs_waitrequest;
  endsequence

  chk_bus_one_wait: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (req && !ack_q) |-> s_bus_wait)
    else $error("bus answer not after one wait cycle");

  chk_off_no_enable: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    !i_enable |=> (st_q == ST_OFF) && !o_core_reg_en)
    else $error("device not idle without enable");

  chk_functional_delay: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (st_q == ST_CORE && st_d == ST_READY)
      |-> dly_q == 16'(P_FUNC_DELAY_CYC - 1))
    else $error("functional delay count wrong");

  chk_wait_for_start: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (st_q == ST_READY && !auto_start_q && !start_req)
      |=> st_q != ST_ON)
    else $error("outputs on without start bit");

  chk_auto_start: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (st_q == ST_READY && auto_start_q && power_ok) |=> o_outputs_on)
    else $error("immediate start missed");

  chk_nvm_load: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (load_now && i_nvm_programmed)
      |=> avdd_q == $past(i_nvm_avdd) && seq_q == $past(i_nvm_seq))
    else $error("stored settings not loaded");

  chk_default_load: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (load_now && !i_nvm_programmed) |=> avdd_q == AVDD_DEF
      && vgon_q == VGON_DEF && vgoff_q == VGOFF_DEF)
    else $error("default levels not used");

  chk_oor_fault_pin: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (i_core_supply_out_of_range && !auto_start_q && st_q != ST_OFF
      && power_ok) |=> oor_q && o_fault_out_n_oe)
    else $error("out-of-range flag or fault pin missing");

  chk_fault_release: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (flt_clr && !i_core_supply_out_of_range) |=> !o_fault_out_n_oe)
    else $error("fault pin held after flag read");

  chk_ro_no_write: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (wr_acc && ro_mode_q && !load_now) |=> $stable(avdd_q)
      && $stable(fsw_q) && $stable(seq_q) && !o_nvm_commit)
    else $error("write took effect in read-only mode");

  chk_early_start: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (st_q == ST_CORE) |=> st_q != ST_ON)
    else $error("outputs on before functional delay");

endmodule // dps_top
`default_nettype wire

// ### dps_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module dps_host_model (
  input wire logic i_clock,
  input wire logic i_power_req,
  input wire logic i_fault_oe,
  output logic o_enable,
  output logic o_vin_above_uvlo,
  output logic o_fault_level
);
  // ********************************************************
  // enable pin and pulled-up fault line
  // ********************************************************
  // the system raises enable only once the strap is settled
  always_ff @(posedge i_clock) begin
    o_enable <= i_power_req;
  end
  assign o_vin_above_uvlo = 1'h1;
  // open drain: the pull-up wins whenever the device lets go
  assign o_fault_level = i_fault_oe ? 1'h0 : 1'h1;
endmodule // dps_host_model
`default_nettype wire

// ### display_power_startup_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module display_power_startup_control_tb_top;
  import dps_pkg::*;
  localparam int unsigned P = 20;
  logic clk, rst, rd, wr, en_req, oor, ro, nvm, pin, en, vin_ok, wreq;
  logic oe, fo, core_en, func, on, commit, dbl, fsw, ss, tick;
  logic [4:0] addr;
  logic [31:0] wdata, rdata, x;
  logic [5:0] nv_a, nv_h, nv_l, avdd, nav, vgon, vgoff;
  logic [2:0] nv_s, seq;
  logic [7:0] cfgs [3] = '{8'h00, 8'h03, 8'h74};
  dps_strap_t strap;
  int miscompares, compares, g;

  // ********************************************************
  // design and far side
  // ********************************************************
  dps_top #(.P_FUNC_DELAY_CYC(P)) dut (.i_clock(clk), .i_sys_rst(rst),
    .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_byteenable(4'hF), .i_avs_writedata(wdata),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_enable(en),
    .i_vin_above_uvlo(vin_ok), .i_core_below_uvlo(1'h0),
    .i_core_supply_out_of_range(oor), .i_addr_strap(strap),
    .i_variant_read_only(ro), .i_nvm_programmed(nvm), .i_nvm_avdd(nv_a),
    .i_nvm_vgon(nv_h), .i_nvm_vgoff(nv_l), .i_nvm_seq(nv_s),
    .i_fault_out_n_in(pin), .o_fault_out_n_o(fo), .o_fault_out_n_oe(oe),
    .o_core_reg_en(core_en), .o_functional(func), .o_outputs_on(on),
    .o_nvm_commit(commit), .o_avdd_level(avdd),
    .o_negative_source_rail_level(nav), .o_vgon_level(vgon),
    .o_vgoff_level(vgoff), .o_seq_select(seq),
    .o_pump_doubler_select(dbl), .o_switch_freq_select(fsw),
    .o_spread_en(ss), .o_sw_tick(tick));
  dps_host_model host (.i_clock(clk), .i_power_req(en_req), .i_fault_oe(oe),
    .o_enable(en), .o_vin_above_uvlo(vin_ok), .o_fault_level(pin));

  // ********************************************************
  // tasks
  // ********************************************************
  task automatic close_out();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // the answer may take up to 20 cycles; past that bound the wait ends and the test fails
  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    n = 0;
    // waitrequest and read data are both taken as they stand at the edge
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        miscompares++;
        close_out();
      end
    end while (wreq !== 1'h0);
    q = rdata;
    rd <= 1'h0;
    wr <= 1'h0;
    @(negedge clk);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'h0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic tick_gap(output int gap);
    int n;
    n = 0;
    while (tick !== 1'h1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    gap = 0;
    do begin
      @(negedge clk);
      gap++;
    end while (tick !== 1'h1 && gap < 200);
  endtask
  // early start lands while the core supply is still settling
  task automatic power(input dps_strap_t s, input logic r, input logic n,
      input logic early);
    @(posedge clk);
    en_req <= 1'h0;
    repeat (4) @(posedge clk);
    strap <= s;
    ro <= r;
    nvm <= n;
    en_req <= 1'h1;
    repeat (4) @(posedge clk);
    if (early) begin
      wr_reg(REG_CTRL_OFS, 32'h1);
    end
    repeat (P + 8) @(posedge clk);
    @(negedge clk);
  endtask

  // ********************************************************
  // stimulus
  // ********************************************************
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    rst = 1'h1;
    rd = 1'h0;
    wr = 1'h0;
    addr = 5'h00;
    wdata = 32'h0;
    en_req = 1'h0;
    oor = 1'h0;
    ro = 1'h0;
    nvm = 1'h0;
    strap = STRAP_LOW;
    nv_a = 6'h33;
    nv_h = 6'h11;
    nv_l = 6'h22;
    nv_s = 3'h5;
    miscompares = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk(avdd, AVDD_DEF);
    chk(vgon, VGON_DEF);
    chk(vgoff, VGOFF_DEF);
    chk(seq, SEQ_DEF);
    chk(core_en, 1'h0);
    rd_chk(5'h1C, 32'h0);
    wr_reg(AVDD_SET_OFS, 32'h3F);
    power(STRAP_LOW, 1'h0, 1'h0, 1'h1);
    chk(core_en, 1'h1);
    chk(func, 1'h1);
    chk(on, 1'h0);
    chk(avdd, AVDD_DEF);
    wr_reg(REG_CTRL_OFS, 32'h1);
    chk(on, 1'h1);
    power(STRAP_CORE, 1'h0, 1'h0, 1'h0);
    chk(on, 1'h0);
    wr_reg(REG_CTRL_OFS, 32'h1);
    chk(on, 1'h1);
    wr_reg(AVDD_SET_OFS, 32'h2A);
    chk(avdd, 6'h2A);
    chk(nav, 6'h2A);
    rd_chk(AVDD_SET_OFS, 32'h2A);
    wr_reg(VGON_SET_OFS, 32'h3F);
    wr_reg(VGOFF_SET_OFS, 32'h01);
    chk(vgon, 6'h3F);
    chk(vgoff, 6'h01);
    for (int i = 0; i < 3; i++) begin
      wr_reg(CONFIG_OFS, {24'h0, cfgs[i]});
      chk(fsw, cfgs[i][0]);
      chk(ss, cfgs[i][1]);
      chk(dbl, cfgs[i][2]);
      chk(seq, cfgs[i][6:4]);
      tick_gap(g);
      x = cfgs[i][0] ? SW_LO_CYC : SW_HI_CYC;
      chk(g >= x && g <= x + (cfgs[i][1] ? 3 : 0), 1'h1);
    end
    wr_reg(REG_CTRL_OFS, 32'h2);
    // the pulse already stands at the negedge that ends the write
    x = 32'(commit);
    repeat (2) begin
      @(negedge clk);
      x = x + 32'(commit);
    end
    chk(x, 32'h1);
    chk(on, 1'h1);
    @(posedge clk);
    oor <= 1'h1;
    @(posedge clk);
    oor <= 1'h0;
    repeat (2) @(negedge clk);
    chk(oe, 1'h1);
    chk(fo, 1'h0);
    chk(pin, 1'h0);
    rd_chk(SECOND_FAULT_REG_OFS, 32'h1);
    rd_chk(SECOND_FAULT_REG_OFS, 32'h0);
    chk(oe, 1'h0);
    power(STRAP_CORE, 1'h1, 1'h1, 1'h0);
    chk(on, 1'h1);
    chk(avdd, 6'h33);
    chk(vgon, 6'h11);
    chk(seq, 3'h5);
    wr_reg(AVDD_SET_OFS, 32'h01);
    rd_chk(AVDD_SET_OFS, 32'h33);
    bus(1'h0, STATUS_OFS, 32'h0, x);
    chk(x[14:8], RO_SERIAL_ADDR);
    chk(x, 32'h0000_291A);
    power(STRAP_LOW, 1'h1, 1'h1, 1'h0);
    chk(on, 1'h1);
    power(STRAP_FLOAT, 1'h0, 1'h1, 1'h0);
    chk(on, 1'h1);
    chk(vgoff, 6'h22);
    @(posedge clk);
    en_req <= 1'h0;
    repeat (4) @(negedge clk);
    chk(core_en, 1'h0);
    chk(on, 1'h0);
    close_out();
  end
endmodule // display_power_startup_control_tb_top
`default_nettype wire
